// ==== ssc_serial_port.sv ====
// Serial control port and register update logic of a frequency synthesizer.
// Assumes serial pins are synchronous to clk_in and far slower than it.
//
// Functional notes
// - Frame starts on rising clock with select low; that edge is MSB.
// - Select rising before full 32 cycles discards the word.
// - Select rising after 32nd falling edge commits the word.
// - Bits 31..3 carry data; bits 2..0 pick register 0 to 7.
// - Register 2 field picks status pin function, eight codes.
// - Power-down loads counters; oscillator, pump, lock, buffers, input off.
// - Serial registers keep loading while powered down.
// - Radio outputs stay muted after power-up until lock.
// - Phase, modulus, reference and pump fields wait for register 0 write.
// - Output divider waits for register 0 only when double buffer set.
// - Read data returns in next access after select high then low.
// - Edge select 1: drive on select fall and falling clock edges.
// - Edge select 0: drive read bits on rising clock edges.
// - Read ends at select rise, MSB first, bits past 32 undefined.
// - Fast lock forces maximum pump current and closes the ground switch.
// - Fast lock length set by 12-bit divide in register 4.
// - Register 0 write starts band selection unless disabled.
`timescale 1ns/1ps
module ssc_serial_port (
   input  wire logic        clk_in,             // 200 MHz system clock
   input  wire logic        nrst_in,            // Async reset, active low
   input  wire logic        sclk_in,            // Serial clock pin
   input  wire logic        chip_select_n_in,   // Frame select, active low
   input  wire logic        sdi_in,             // Serial data in
   input  wire logic        read_edge_select_in,// 1: drive on falling edges
   input  wire logic        power_down_in,      // Power-down request
   input  wire logic        lock_detect_in,     // Loop lock indication
   input  wire logic        ref_count_in,       // Reference counter output
   input  wire logic        fb_count_in,        // Feedback counter output
   input  wire logic        fast_lock_in,       // Fast lock mode enable
   input  wire logic        pfd_tick_in,        // Fast lock timer enable
   output logic             mux_out,            // Status pin level
   output logic             mux_oe_out,         // Status pin drive enable
   output logic [11:0]      phase_out,          // Active phase value
   output logic [11:0]      modulus_out,        // Active modulus
   output logic             reference_doubler_out, // Active doubler
   output logic             reference_halver_out,  // Active halver
   output logic [9:0]       ref_counter_out,    // Active reference count
   output logic [3:0]       charge_pump_current_out, // Pump current code
   output logic             fast_lock_switch_out,    // Damping switch closed
   output logic [2:0]       output_divider_out, // Active output divider
   output logic             band_select_start_out,   // Band select pulse
   output logic             counters_load_out,  // Counters held at load
   output logic             osc_power_down_out, // Oscillator off
   output logic             cp_tristate_out,    // Charge pump released
   output logic             lock_detect_reset_out, // Lock detect cleared
   output logic             output_buffers_off_out, // Radio buffers off
   output logic             input_stage_off_out,    // Input stage off
   output logic             radio_mute_out      // Radio outputs muted
);
   typedef struct packed {
      logic             sclk_q;
      logic             cs_q;
      logic             active;
      logic [5:0]       rcnt;
      logic [5:0]       fcnt;
      logic [31:0]      shift;
      logic [7:0][31:0] regs;
      logic [11:0]      phase;
      logic [11:0]      modulus;
      logic             dbl;
      logic             halv;
      logic [9:0]       rcount;
      logic [3:0]       charge_pump_current;
      logic [2:0]       odiv;
      logic             rd_pend;
      logic [2:0]       rd_addr;
      logic             reading;
      logic [31:0]      rd_shift;
      logic             sdo;
      logic             mux;
      logic             mux_oe;
      logic             pd;
      logic             muted;
      logic             band_start;
      logic             fl_start;
      logic [3:0]       cp_cur;
      logic             fast_lock_switch;
   } ssc_state_t;

   ssc_state_t  r, n;
   logic        rise, fall, cs_rise, cs_fall, commit, reg0_wr, fl_busy;
   logic [2:0]  code, mux_sel;
   logic [31:0] rd_word;

   ssc_fast_lock_timer u_timer (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .start_in  (r.fl_start),
      .divide_in (r.regs[ssc_pkg::REG_OUT][ssc_pkg::CDIV_LSB +: 12]),
      .tick_in   (pfd_tick_in),
      .busy_out  (fl_busy)
   );

   always_comb begin
      n        = r;
      rise     = sclk_in & ~r.sclk_q;
      fall     = ~sclk_in & r.sclk_q;
      cs_rise  = chip_select_n_in & ~r.cs_q;
      cs_fall  = ~chip_select_n_in & r.cs_q;
      code     = r.shift[ssc_pkg::CODE_LSB +: ssc_pkg::CODE_W];
      rd_word  = r.regs[r.rd_addr];
      // Exactly 32 rising and 32 falling edges, else the word is dropped
      commit   = cs_rise && r.active && r.rcnt == ssc_pkg::FRAME_BITS
                 && r.fcnt == ssc_pkg::FRAME_BITS;
      reg0_wr  = commit && code == ssc_pkg::REG_ZERO;
      n.sclk_q = sclk_in;
      n.cs_q   = chip_select_n_in;
      n.band_start = 1'b0;
      n.fl_start   = 1'b0;

      // Shift in; runs regardless of power-down
      if (!chip_select_n_in && rise) begin
         n.shift = {r.shift[30:0], sdi_in};
         if (!r.active) begin
            n.active = 1'b1;
            n.rcnt   = 6'h01;
            n.fcnt   = 6'h00;
         end else if (r.rcnt != ssc_pkg::CNT_MAX) begin
            n.rcnt = r.rcnt + 6'h01;
         end
      end
      if (!chip_select_n_in && fall && r.active
          && r.fcnt != ssc_pkg::CNT_MAX) begin
         n.fcnt = r.fcnt + 6'h01;
      end
      if (chip_select_n_in) begin
         n.active = 1'b0;
      end
      if (commit) begin
         n.regs[code] = r.shift;
         if (code == ssc_pkg::REG_INSTR
             && r.shift[ssc_pkg::RD_REQ_BIT]) begin
            n.rd_pend = 1'b1;
            n.rd_addr = r.shift[ssc_pkg::RD_ADDR_LSB +: 3];
         end
      end

      // Shadowed fields move to active copies on a register 0 write
      if (reg0_wr) begin
         n.phase   = r.regs[ssc_pkg::REG_PHASE][ssc_pkg::PHASE_LSB +: 12];
         n.modulus = r.regs[ssc_pkg::REG_PHASE][ssc_pkg::MOD_LSB +: 12];
         n.dbl     = r.regs[ssc_pkg::REG_CTRL][ssc_pkg::DBL_BIT];
         n.halv    = r.regs[ssc_pkg::REG_CTRL][ssc_pkg::HALV_BIT];
         n.rcount  = r.regs[ssc_pkg::REG_CTRL][ssc_pkg::RCNT_LSB +: 10];
         n.charge_pump_current     = r.regs[ssc_pkg::REG_CTRL][ssc_pkg::ICP_LSB +: 4];
         n.band_start = ~r.regs[ssc_pkg::REG_PHASE][ssc_pkg::BSD_BIT];
         n.fl_start   = fast_lock_in;
      end
      if (reg0_wr || !n.regs[ssc_pkg::REG_CTRL][ssc_pkg::DBUF_BIT]) begin
         n.odiv = n.regs[ssc_pkg::REG_OUT][ssc_pkg::ODIV_LSB +: 3];
      end

      // Read-back shifter; frames carry writes all the same
      if (cs_fall && r.rd_pend) begin
         n.rd_pend = 1'b0;
         n.reading = 1'b1;
         n.rd_shift = rd_word;
         if (read_edge_select_in) begin
            n.sdo      = rd_word[31];
            n.rd_shift = {rd_word[30:0], 1'b0};
         end
      end else if (r.reading && !chip_select_n_in
                   && ((fall && read_edge_select_in)
                   || (rise && !read_edge_select_in))) begin
         n.sdo      = r.rd_shift[31];
         n.rd_shift = {r.rd_shift[30:0], 1'b0};
      end
      if (chip_select_n_in) begin
         n.reading = 1'b0;
      end

      mux_sel  = r.regs[ssc_pkg::REG_CTRL][ssc_pkg::MUX_LSB +: 3];
      n.mux    = 1'b0;
      n.mux_oe = 1'b1;
      unique case (mux_sel)
         ssc_pkg::MUX_HIZ:    n.mux_oe = 1'b0;
         ssc_pkg::MUX_HIGH:   n.mux    = 1'b1;
         ssc_pkg::MUX_LOW:    n.mux    = 1'b0;
         ssc_pkg::MUX_REFCNT: n.mux    = ref_count_in;
         ssc_pkg::MUX_FBCNT:  n.mux    = fb_count_in;
         ssc_pkg::MUX_RSVD:   n.mux_oe = 1'b0;
         ssc_pkg::MUX_LOCK:   n.mux    = lock_detect_in;
         ssc_pkg::MUX_SDO:    n.mux    = n.sdo;
      endcase

      n.pd = power_down_in;
      if (power_down_in) begin
         n.muted = 1'b1;
      end else if (lock_detect_in) begin
         n.muted = 1'b0;
      end
      // Fast lock overrides pump current while the timer runs
      n.fast_lock_switch   = fl_busy;
      n.cp_cur = fl_busy ? ssc_pkg::ICP_MAX : n.charge_pump_current;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r       <= '0;
         r.cs_q  <= 1'b1;
         r.muted <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign mux_out                 = r.mux;
   assign mux_oe_out              = r.mux_oe;
   assign phase_out               = r.phase;
   assign modulus_out             = r.modulus;
   assign reference_doubler_out   = r.dbl;
   assign reference_halver_out    = r.halv;
   assign ref_counter_out         = r.rcount;
   assign charge_pump_current_out = r.cp_cur;
   assign fast_lock_switch_out    = r.fast_lock_switch;
   assign output_divider_out      = r.odiv;
   assign band_select_start_out   = r.band_start;
   assign counters_load_out       = r.pd;
   assign osc_power_down_out      = r.pd;
   assign cp_tristate_out         = r.pd;
   assign lock_detect_reset_out   = r.pd;
   assign output_buffers_off_out  = r.pd;
   assign input_stage_off_out     = r.pd;
   assign radio_mute_out          = r.muted;

   frame_start_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      !chip_select_n_in && rise && !r.active
      |=> r.active && r.rcnt == 6'h01 && r.shift[0] == $past(sdi_in))
      else $error("frame did not start on first rising edge");

   short_frame_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      cs_rise && r.rcnt != ssc_pkg::FRAME_BITS
      |=> $stable(r.regs) && !band_select_start_out)
      else $error("aborted frame changed a register");

   word_commit_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      commit |=> r.regs[$past(code)] == $past(r.shift))
      else $error("complete frame not committed");

   pin_drive_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      mux_sel == ssc_pkg::MUX_HIGH ##1 mux_sel == ssc_pkg::MUX_HIGH
      |-> mux_out && mux_oe_out)
      else $error("status pin not driven high");

   power_down_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      power_down_in |=> osc_power_down_out && cp_tristate_out
      && input_stage_off_out && radio_mute_out)
      else $error("power-down effects missing");

   mute_hold_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      radio_mute_out && !lock_detect_in |=> radio_mute_out)
      else $error("outputs unmuted without lock");

   shadow_hold_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      !reg0_wr |=> $stable(phase_out) && $stable(ref_counter_out))
      else $error("shadowed field changed without register 0 write");

   read_msb_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      cs_fall && r.rd_pend && read_edge_select_in
      && mux_sel == ssc_pkg::MUX_SDO
      |=> ##1 mux_out == $past(rd_word[31], 2))
      else $error("read MSB not presented at select fall");

   fast_pump_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      fl_busy |=> charge_pump_current_out == ssc_pkg::ICP_MAX
      && fast_lock_switch_out)
      else $error("fast lock did not force pump current");

   band_start_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      reg0_wr && !r.regs[ssc_pkg::REG_PHASE][ssc_pkg::BSD_BIT]
      |=> band_select_start_out ##1 !band_select_start_out)
      else $error("band selection not started");
endmodule : ssc_serial_port

// ==== ssc_pkg.sv ====
// Constants for the synthesizer serial control port.
// Assumes a single 200 MHz system clock samples all serial pins.
package ssc_pkg;
   localparam int unsigned WORD_W      = 32;
   localparam int unsigned NUM_REGS    = 8;
   localparam logic [5:0]  FRAME_BITS  = 6'h20;
   localparam logic [5:0]  CNT_MAX     = 6'h3F;
   // Serial word layout
   localparam int unsigned CODE_LSB    = 0;
   localparam int unsigned CODE_W      = 3;
   // Registers 0 and 1
   localparam logic [2:0]  REG_ZERO    = 3'h0;
   localparam logic [2:0]  REG_PHASE   = 3'h1;
   localparam int unsigned PHASE_LSB   = 15;
   localparam int unsigned PHASE_W     = 12;
   localparam int unsigned MOD_LSB     = 3;
   localparam int unsigned MOD_W       = 12;
   localparam int unsigned BSD_BIT     = 28;
   // Register 2
   localparam logic [2:0]  REG_CTRL    = 3'h2;
   localparam int unsigned MUX_LSB     = 26;
   localparam int unsigned MUX_W       = 3;
   localparam int unsigned DBL_BIT     = 25;
   localparam int unsigned HALV_BIT    = 24;
   localparam int unsigned RCNT_LSB    = 14;
   localparam int unsigned RCNT_W      = 10;
   localparam int unsigned DBUF_BIT    = 13;
   localparam int unsigned ICP_LSB     = 9;
   localparam int unsigned ICP_W       = 4;
   localparam logic [3:0]  ICP_MAX     = 4'hF;
   // Register 4
   localparam logic [2:0]  REG_OUT     = 3'h4;
   localparam int unsigned ODIV_LSB    = 20;
   localparam int unsigned ODIV_W      = 3;
   localparam int unsigned CDIV_LSB    = 3;
   localparam int unsigned CDIV_W      = 12;
   // Register 7
   localparam logic [2:0]  REG_INSTR   = 3'h7;
   localparam int unsigned RD_REQ_BIT  = 3;
   localparam int unsigned RD_ADDR_LSB = 4;
   localparam int unsigned RD_ADDR_W   = 3;
   // Status pin functions
   localparam logic [2:0]  MUX_HIZ     = 3'h0;
   localparam logic [2:0]  MUX_HIGH    = 3'h1;
   localparam logic [2:0]  MUX_LOW     = 3'h2;
   localparam logic [2:0]  MUX_REFCNT  = 3'h3;
   localparam logic [2:0]  MUX_FBCNT   = 3'h4;
   localparam logic [2:0]  MUX_RSVD    = 3'h5;
   localparam logic [2:0]  MUX_LOCK    = 3'h6;
   localparam logic [2:0]  MUX_SDO     = 3'h7;
   // Reset value and unit timer count
   localparam logic [31:0] REG_RESET   = 32'h0000_0000;
   localparam logic [11:0] CDIV_ONE    = 12'h001;
endpackage : ssc_pkg

// ==== ssc_fast_lock_timer.sv ====
// Fast-lock duration timer: counts reference ticks down from a divide value.
// Assumes tick_in is a one-cycle enable in the clk_in domain.
`timescale 1ns/1ps
module ssc_fast_lock_timer (
   input  wire logic        clk_in,     // System clock
   input  wire logic        nrst_in,    // Async reset, active low
   input  wire logic        start_in,   // Start pulse
   input  wire logic [11:0] divide_in,  // Tick count to hold
   input  wire logic        tick_in,    // Counting enable
   output logic             busy_out    // Fast lock active
);
   typedef struct packed {
      logic        busy;
      logic [11:0] cnt;
   } ssc_tmr_t;

   ssc_tmr_t r, n;

   always_comb begin
      n = r;
      if (start_in) begin
         n.busy = 1'b1;
         // Zero divide loads as one; the timer then holds for one tick
         n.cnt  = (divide_in == 12'h000) ? ssc_pkg::CDIV_ONE : divide_in;
      end else if (r.busy && tick_in) begin
         if (r.cnt <= ssc_pkg::CDIV_ONE) begin
            n.busy = 1'b0;
         end else begin
            n.cnt = r.cnt - ssc_pkg::CDIV_ONE;
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign busy_out = r.busy;

   timer_expire_a:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      r.busy && tick_in && !start_in && r.cnt == 12'h001 |=> !busy_out)
      else $error("fast lock timer did not expire");
endmodule : ssc_fast_lock_timer

// ==== ssc_spi_master.sv ====
// SPI master model facing the synthesizer serial control port.
// Assumes the bench clock on clk_in; pins move only at its falling edge.
`timescale 1ns/1ps
module ssc_spi_master (
   input  wire logic clk_in,              // Bench clock
   input  wire logic status_pin_in,       // Resolved status pin level
   input  wire logic read_edge_select_in, // 1: capture on sclk rise
   output logic      sclk_out,            // Serial clock, idles low
   output logic      chip_select_n_out,   // Frame select, active low
   output logic      sdi_out              // Serial data to device
);
   // Four clocks high and eight low keep clear of the two-clock sampling floor
   localparam int HALF = 4;
   logic [31:0] rd_word;  // Bits captured in the last frame

   initial begin
      sclk_out          = 1'b0;
      chip_select_n_out = 1'b1;
      sdi_out           = 1'b0;
      rd_word           = 32'h0000_0000;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_in);
   endtask : wait_clk

   // Fewer than 32 bits ends the frame early, so the device must drop it
   task automatic xfer(input logic [31:0] word, input int nbits);
      rd_word = 32'h0000_0000;
      chip_select_n_out <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         wait_clk(HALF);
         sdi_out <= word[31-i];
         wait_clk(HALF);
         if (read_edge_select_in)
            rd_word[31-i] = status_pin_in;
         sclk_out <= 1'b1;
         wait_clk(HALF);
         if (!read_edge_select_in)
            rd_word[31-i] = status_pin_in;
         sclk_out <= 1'b0;
      end
      wait_clk(HALF);
      chip_select_n_out <= 1'b1;
      // Released line must not keep showing the last bit
      sdi_out <= ~sdi_out;
      wait_clk(6);
   endtask : xfer
endmodule : ssc_spi_master

// ==== ssc_tb.sv ====
// Self-checking bench for the synthesizer serial control port.
// Assumes ssc_pkg, ssc_serial_port and ssc_spi_master compiled first.
`timescale 1ns/1ps
module tb;
   logic        clk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic        read_edge_select_in = 1'b1;
   logic        power_down_in = 1'b0, lock_detect_in = 1'b0;
   logic        ref_count_in = 1'b0, fb_count_in = 1'b0;
   logic        fast_lock_in = 1'b0, pfd_tick_in = 1'b0;
   wire         sclk_in, chip_select_n_in, sdi_in, status_pin;
   logic        mux_out, mux_oe_out, reference_doubler_out;
   logic        reference_halver_out, fast_lock_switch_out;
   logic        band_select_start_out, counters_load_out;
   logic        osc_power_down_out, cp_tristate_out, lock_detect_reset_out;
   logic        output_buffers_off_out, input_stage_off_out, radio_mute_out;
   logic [11:0] phase_out, modulus_out;
   logic [9:0]  ref_counter_out;
   logic [3:0]  charge_pump_current_out;
   logic [2:0]  output_divider_out;
   logic [31:0] r0, r1, r2, r4, r7, w;
   logic [31:0] seed = 32'hd18a_e5fc;
   logic [31:0] band_cnt = 32'h0000_0000;
   logic [1:0]  e;
   int          mismatches = 0, check_count = 0, n;

   always #2.5 clk_in = ~clk_in;
   assign status_pin = mux_oe_out ? mux_out : 1'bz;
   always @(posedge clk_in)
      if (band_select_start_out === 1'b1)
         band_cnt <= band_cnt + 32'h0000_0001;

   ssc_serial_port uut (
      .clk_in, .nrst_in, .sclk_in, .chip_select_n_in, .sdi_in,
      .read_edge_select_in, .power_down_in, .lock_detect_in, .ref_count_in,
      .fb_count_in, .fast_lock_in, .pfd_tick_in, .mux_out, .mux_oe_out,
      .phase_out, .modulus_out, .reference_doubler_out,
      .reference_halver_out, .ref_counter_out, .charge_pump_current_out,
      .fast_lock_switch_out, .output_divider_out, .band_select_start_out,
      .counters_load_out, .osc_power_down_out, .cp_tristate_out,
      .lock_detect_reset_out, .output_buffers_off_out, .input_stage_off_out,
      .radio_mute_out
   );
   ssc_spi_master mst (
      .clk_in, .status_pin_in(status_pin), .read_edge_select_in,
      .sclk_out(sclk_in), .chip_select_n_out(chip_select_n_in),
      .sdi_out(sdi_in)
   );

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Expected {drive enable, level} of the status pin
   function automatic logic [1:0] mux_exp(input logic [2:0] c);
      case (c)
         3'h1: return 2'b11;
         3'h2: return 2'b10;
         3'h3: return {1'b1, ref_count_in};
         3'h4: return {1'b1, fb_count_in};
         3'h6: return {1'b1, lock_detect_in};
         default: return 2'b00;
      endcase
   endfunction : mux_exp

   task automatic wrap_up();
      if (mismatches == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask : check

   task automatic wr(input logic [31:0] word);
      mst.xfer(word, 32);
   endtask : wr

   task automatic check_active();
      check(32'(phase_out), 32'(r1[26:15]), "phase");
      check(32'(modulus_out), 32'(r1[14:3]), "modulus");
      w = 32'({reference_doubler_out, reference_halver_out});
      check(w, 32'(r2[25:24]), "doubler halver");
      check(32'(ref_counter_out), 32'(r2[23:14]), "ref count");
      check(32'(charge_pump_current_out), 32'(r2[12:9]), "icp");
   endtask : check_active

   initial begin
      repeat (20) @(negedge clk_in);
      nrst_in <= 1'b1;
      repeat (2) @(negedge clk_in);
      w = 32'({radio_mute_out, mux_oe_out, fast_lock_switch_out});
      check(w, 32'h0000_0004, "reset state");
      r4 = rnd();
      r4[14:0] = {12'h003, 3'h4};
      r2 = rnd();
      r2[28:26] = 3'h1;
      r2[13] = 1'b0;
      r2[2:0] = 3'h2;
      r1 = rnd();
      r1[28] = 1'b0;
      r1[2:0] = 3'h1;
      r0 = rnd() & 32'hFFFF_FFF8;
      wr(r4);
      check(32'(output_divider_out), 32'(r4[22:20]), "odiv");
      wr(r2);
      wr(r1);
      check(32'(phase_out), 32'h0000_0000, "early phase");
      wr(r0);
      check_active();
      check(band_cnt, 32'h0000_0001, "band select");
      w = rnd();
      w[2:0] = 3'h1;
      mst.xfer(w, 31);
      wr(r0);
      check_active();
      check(band_cnt, 32'h0000_0002, "band select");
      r1 = rnd();
      r1[28] = 1'b1;
      r1[2:0] = 3'h1;
      wr(r1);
      wr(r0);
      check_active();
      check(band_cnt, 32'h0000_0002, "band disabled");
      r2[13] = 1'b1;
      wr(r2);
      w = r4;
      r4[22:20] = r4[22:20] + 3'h1;
      wr(r4);
      check(32'(output_divider_out), 32'(w[22:20]), "odiv held");
      wr(r0);
      check(32'(output_divider_out), 32'(r4[22:20]), "odiv");
      for (int c = 0; c < 7; c++) begin
         w = rnd();
         {ref_count_in, fb_count_in, lock_detect_in} <= w[2:0];
         r2[28:26] = 3'(c);
         wr(r2);
         e = mux_exp(r2[28:26]);
         check(32'(mux_oe_out), 32'(e[1]), "mux enable");
         if (e[1])
            check(32'(mux_out), 32'(e[0]), "mux level");
      end
      for (int es = 1; es >= 0; es--) begin
         read_edge_select_in <= es[0];
         r2[28:26] = 3'h7;
         wr(r2);
         r7 = rnd();
         r7[6:0] = {es[0] ? 3'h1 : 3'h2, 1'b1, 3'h7};
         wr(r7);
         w = es[0] ? r1 : r2;
         mst.xfer(r7 & 32'hFFFF_FFF7, 32);
         check(mst.rd_word, w, "read word");
         wr(r7);
         mst.xfer(r7 & 32'hFFFF_FFF7, 16);
         check(32'(mst.rd_word[31:16]), 32'(w[31:16]), "short rd");
      end
      lock_detect_in <= 1'b0;
      power_down_in <= 1'b1;
      repeat (2) @(negedge clk_in);
      w = 32'({counters_load_out, osc_power_down_out, cp_tristate_out,
               lock_detect_reset_out, output_buffers_off_out,
               input_stage_off_out, radio_mute_out});
      check(w, 32'h0000_007F, "power down");
      r1 = rnd();
      r1[2:0] = 3'h1;
      wr(r1);
      wr(r0);
      check_active();
      power_down_in <= 1'b0;
      repeat (4) @(negedge clk_in);
      check(32'(radio_mute_out), 32'h0000_0001, "mute held");
      lock_detect_in <= 1'b1;
      repeat (4) @(negedge clk_in);
      check(32'(radio_mute_out), 32'h0000_0000, "mute cleared");
      fast_lock_in <= 1'b1;
      wr(r0);
      w = 32'({fast_lock_switch_out, charge_pump_current_out});
      check(w, 32'h0000_001F, "fast lock on");
      fast_lock_in <= 1'b0;
      for (int t = 0; t < 3; t++) begin
         check(32'(fast_lock_switch_out), 32'h0000_0001, "fl held");
         pfd_tick_in <= 1'b1;
         @(negedge clk_in);
         pfd_tick_in <= 1'b0;
         repeat (3) @(negedge clk_in);
      end
      n = 0;
      while (fast_lock_switch_out !== 1'b0 && n < 10) begin
         @(negedge clk_in);
         n++;
      end
      if (n == 10) begin
         mismatches++;
         wrap_up();
      end
      w = 32'({fast_lock_switch_out, charge_pump_current_out});
      check(w, 32'(r2[12:9]), "fast lock off");
      wrap_up();
   end
endmodule : tb
